//--- inc/irc_pkg.sv
// Package: constants for the interrupt routing and exception control block
package irc_pkg;
  // ****************************************
  // Address map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 14;
  localparam logic [13:0] OFF_IRCT_SRC = 14'h0078;
  localparam logic [13:0] OFF_RTC_SRC = 14'h007c;
  localparam logic [13:0] OFF_NMI_SELECT = 14'h0080;
  localparam logic [13:0] OFF_REQ_VECTOR = 14'h0084;
  localparam logic [13:0] OFF_UNLOCK_PORT = 14'h0100;
  localparam logic [13:0] OFF_CORE_ID = 14'h0d00;
  localparam logic [13:0] OFF_PEND_STATE = 14'h0d04;
  localparam logic [13:0] OFF_KEYED_RESET = 14'h0d0c;
  localparam logic [13:0] OFF_SLEEP_CTRL = 14'h0d10;
  localparam logic [13:0] OFF_HPRI_TWO = 14'h0d1c;
  localparam logic [13:0] OFF_HPRI_THREE = 14'h0d20;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int NMI_EN_BIT = 8;
  localparam int NMI_PICK_W = 5;
  localparam int NMI_SET_BIT = 31;
  localparam int PSV_SET_BIT = 28;
  localparam int PSV_CLR_BIT = 27;
  localparam int TICK_SET_BIT = 26;
  localparam int TICK_CLR_BIT = 25;
  localparam int AFTER_HALT_BIT = 23;
  localparam int ANY_WAIT_BIT = 22;
  localparam int TOP_WAIT_LSB = 12;
  localparam int RESET_REQ_BIT = 2;
  localparam int WIPE_ACT_BIT = 1;
  localparam int KEY_LSB = 16;
  // ****************************************
  // Values
  // ****************************************
  localparam logic [7:0] UNLOCK_B0 = 8'h59;
  localparam logic [7:0] UNLOCK_B1 = 8'h16;
  localparam logic [7:0] UNLOCK_B2 = 8'h88;
  localparam logic [15:0] WRITE_KEY = 16'h05fa;
  localparam logic [31:0] KEYED_RESET_READ = 32'hfa05_0000;
  localparam logic [31:0] SLEEP_CTRL_MASK = 32'h0000_0016;
  localparam logic [31:0] HPRI_TWO_MASK = 32'hc000_0000;
  localparam logic [31:0] HPRI_THREE_MASK = 32'hc0c0_0000;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_DEFERRED = 6'h0e;
  localparam logic [5:0] EXC_TICK = 6'h0f;
  localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
endpackage : irc_pkg

//--- inc/irc_link_if.sv
// Interface: link between the interrupt controller and the core/peripheral side
`timescale 1ns/1ns
`default_nettype none
interface irc_link_if;
  // Register access
  logic wr;
  logic rd;
  logic [13:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;
  // Peripheral lines, asynchronous to clk
  logic [31:0] periph_req;
  // Towards the core
  logic [31:0] core_irq;
  logic core_nmi;
  logic wipe_active;
  logic chip_reset_req;
  // Core status
  logic entry_valid;
  logic [5:0] entry_num;
  logic [5:0] active_num;
  logic halted;

  modport ctrl (
    input wr, rd, addr, wdata, periph_req, entry_valid, entry_num, active_num, halted,
    output rdata, rvalid, core_irq, core_nmi, wipe_active, chip_reset_req
  );
  modport core (
    output wr, rd, addr, wdata, periph_req, entry_valid, entry_num, active_num, halted,
    input rdata, rvalid, core_irq, core_nmi, wipe_active, chip_reset_req
  );
endinterface : irc_link_if
`default_nettype wire

//--- verilog/irc_ctrl.sv
// Interrupt routing and exception control: controller end
`timescale 1ns/1ns
`default_nettype none
module irc_ctrl #(
  parameter logic [7:0] IMPL_CODE = 8'h5a,  // Arbitrary value
  parameter logic [3:0] ARCH_CODE = 4'h3,   // Arbitrary value
  parameter logic [11:0] PART_CODE = 12'h123, // Arbitrary value
  parameter logic [3:0] REV_CODE = 4'h1     // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Link
  irc_link_if.ctrl link
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    UNLOCK_IDLE = 2'b00,
    UNLOCK_FIRST = 2'b01,
    UNLOCK_SECOND = 2'b10
  } irc_unlock_e;

  typedef struct packed {
    irc_unlock_e unlock_step;
    logic unlocked;
    logic nmi_en;
    logic [4:0] nmi_sel;
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] force_set;
    logic [31:0] squash;
    logic nmi_line_d;
    logic nmi_pend;
    logic dsv_pend;
    logic tick_pend;
    logic [31:0] sleep_ctrl;
    logic [31:0] hpri_two;
    logic [31:0] hpri_three;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] irq;
    logic nmi;
    logic wipe;
    logic rst_req;
  } irc_ctrl_s;

  irc_ctrl_s st;
  irc_ctrl_s next_st;
  logic [31:0] req_vec;
  logic nmi_line;
  logic [5:0] top_num;
  logic any_wait;
  logic [31:0] rd_mux;
  logic key_ok;

  // ****************************************
  // Combinational
  // ****************************************
  always_comb begin
    req_vec = (st.sync2 & ~st.squash) | st.force_set;
    nmi_line = st.nmi_en & req_vec[st.nmi_sel];
    any_wait = (|req_vec) | st.dsv_pend | st.tick_pend;
    // Fixed order: lower exception number wins; handler priorities are not applied
    top_num = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (req_vec[i]) begin
        top_num = irc_pkg::EXC_IRQ_BASE + 6'(i);
      end
    end
    if (st.tick_pend) begin
      top_num = irc_pkg::EXC_TICK;
    end
    if (st.dsv_pend) begin
      top_num = irc_pkg::EXC_DEFERRED;
    end
    if (st.nmi_pend) begin
      top_num = irc_pkg::EXC_NMI;
    end
    key_ok = link.wdata[31:irc_pkg::KEY_LSB] == irc_pkg::WRITE_KEY;

    rd_mux = 32'h0000_0000;
    case (link.addr)
      irc_pkg::OFF_IRCT_SRC: rd_mux = {31'h0, req_vec[30]};
      irc_pkg::OFF_RTC_SRC: rd_mux = {31'h0, req_vec[31]};
      irc_pkg::OFF_NMI_SELECT: rd_mux = {23'h0, st.nmi_en, 3'h0, st.nmi_sel};
      irc_pkg::OFF_REQ_VECTOR: rd_mux = req_vec;
      irc_pkg::OFF_UNLOCK_PORT: rd_mux = {31'h0, st.unlocked};
      irc_pkg::OFF_CORE_ID: rd_mux = {IMPL_CODE, 4'h0, ARCH_CODE, PART_CODE, REV_CODE};
      irc_pkg::OFF_PEND_STATE: begin
        rd_mux[irc_pkg::NMI_SET_BIT] = st.nmi_pend;
        rd_mux[irc_pkg::PSV_SET_BIT] = st.dsv_pend;
        rd_mux[irc_pkg::TICK_SET_BIT] = st.tick_pend;
        rd_mux[irc_pkg::AFTER_HALT_BIT] = link.halted & (top_num != 6'h00);
        rd_mux[irc_pkg::ANY_WAIT_BIT] = any_wait;
        rd_mux[irc_pkg::TOP_WAIT_LSB +: 6] = top_num;
        rd_mux[5:0] = link.active_num;
      end
      irc_pkg::OFF_KEYED_RESET: rd_mux = irc_pkg::KEYED_RESET_READ;
      irc_pkg::OFF_SLEEP_CTRL: rd_mux = st.sleep_ctrl;
      irc_pkg::OFF_HPRI_TWO: rd_mux = st.hpri_two;
      irc_pkg::OFF_HPRI_THREE: rd_mux = st.hpri_three;
      default: rd_mux = 32'h0000_0000;
    endcase

    next_st = st;
    next_st.sync1 = link.periph_req;
    next_st.sync2 = st.sync1;
    // A test clear only lasts while the line stays high
    next_st.squash = st.squash & st.sync2;
    next_st.rvalid = link.rd;
    next_st.rdata = link.rd ? rd_mux : 32'h0000_0000;
    next_st.wipe = 1'b0;

    // Clears first, so a same-cycle set wins below
    if (link.entry_valid) begin
      if (link.entry_num == irc_pkg::EXC_NMI) begin
        next_st.nmi_pend = 1'b0;
      end
      if (link.entry_num == irc_pkg::EXC_DEFERRED) begin
        next_st.dsv_pend = 1'b0;
      end
      if (link.entry_num == irc_pkg::EXC_TICK) begin
        next_st.tick_pend = 1'b0;
      end
    end

    if (link.wr) begin
      case (link.addr)
        irc_pkg::OFF_UNLOCK_PORT: begin
          // Any write off the sequence, or any write once open, relocks
          next_st.unlocked = 1'b0;
          next_st.unlock_step = UNLOCK_IDLE;
          case (st.unlock_step)
            UNLOCK_IDLE: begin
              if (link.wdata[7:0] == irc_pkg::UNLOCK_B0) begin
                next_st.unlock_step = UNLOCK_FIRST;
              end
            end
            UNLOCK_FIRST: begin
              if (link.wdata[7:0] == irc_pkg::UNLOCK_B1) begin
                next_st.unlock_step = UNLOCK_SECOND;
              end
            end
            UNLOCK_SECOND: begin
              next_st.unlocked = link.wdata[7:0] == irc_pkg::UNLOCK_B2;
            end
            default: begin
              next_st.unlock_step = UNLOCK_IDLE;
            end
          endcase
        end
        irc_pkg::OFF_NMI_SELECT: begin
          next_st.nmi_sel = link.wdata[irc_pkg::NMI_PICK_W-1:0];
          if (st.unlocked) begin
            next_st.nmi_en = link.wdata[irc_pkg::NMI_EN_BIT];
          end
        end
        irc_pkg::OFF_REQ_VECTOR: begin
          for (int n = 0; n < 32; n++) begin
            if (link.wdata[n]) begin
              if (req_vec[n]) begin
                next_st.force_set[n] = 1'b0;
                next_st.squash[n] = 1'b1;
              end else begin
                next_st.force_set[n] = 1'b1;
                next_st.squash[n] = 1'b0;
              end
            end
          end
        end
        irc_pkg::OFF_PEND_STATE: begin
          if (link.wdata[irc_pkg::PSV_CLR_BIT]) begin
            next_st.dsv_pend = 1'b0;
          end
          if (link.wdata[irc_pkg::TICK_CLR_BIT]) begin
            next_st.tick_pend = 1'b0;
          end
          if (link.wdata[irc_pkg::NMI_SET_BIT]) begin
            next_st.nmi_pend = 1'b1;
          end
          if (link.wdata[irc_pkg::PSV_SET_BIT]) begin
            next_st.dsv_pend = 1'b1;
          end
          if (link.wdata[irc_pkg::TICK_SET_BIT]) begin
            next_st.tick_pend = 1'b1;
          end
        end
        irc_pkg::OFF_KEYED_RESET: begin
          // Keyless writes are dropped whole
          if (key_ok) begin
            if (link.wdata[irc_pkg::RESET_REQ_BIT]) begin
              next_st.rst_req = 1'b1;
            end
            next_st.wipe = link.wdata[irc_pkg::WIPE_ACT_BIT] & link.halted;
          end
        end
        irc_pkg::OFF_SLEEP_CTRL: next_st.sleep_ctrl = link.wdata & irc_pkg::SLEEP_CTRL_MASK;
        irc_pkg::OFF_HPRI_TWO: next_st.hpri_two = link.wdata & irc_pkg::HPRI_TWO_MASK;
        irc_pkg::OFF_HPRI_THREE: next_st.hpri_three = link.wdata & irc_pkg::HPRI_THREE_MASK;
        default: begin
        end
      endcase
    end

    // Rising selected line makes the NMI pending; set beats handler-entry clear
    next_st.nmi_line_d = nmi_line;
    if (nmi_line && !st.nmi_line_d) begin
      next_st.nmi_pend = 1'b1;
    end
    next_st.irq = req_vec;
    next_st.nmi = nmi_line;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.rdata = st.rdata;
  assign link.rvalid = st.rvalid;
  assign link.core_irq = st.irq;
  assign link.core_nmi = st.nmi;
  assign link.wipe_active = st.wipe;
  assign link.chip_reset_req = st.rst_req;
endmodule : irc_ctrl
`default_nettype wire

//--- verilog/irc_core.sv
// Interrupt routing and exception control: core and peripheral end
`timescale 1ns/1ns
`default_nettype none
module irc_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register commands from software
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [13:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // Peripheral lines and core status
  input wire logic [31:0] periph_req_i,
  input wire logic entry_valid_i,
  input wire logic [5:0] entry_num_i,
  input wire logic [5:0] active_num_i,
  input wire logic halted_i,
  // Core-side results
  output logic [31:0] core_irq_o,
  output logic core_nmi_o,
  output logic wipe_active_o,
  output logic chip_reset_req_o,
  // Link
  irc_link_if.core link
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [13:0] addr;
    logic [31:0] wdata;
    logic entry_valid;
    logic [5:0] entry_num;
    logic [5:0] active_num;
    logic halted;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] irq;
    logic nmi;
    logic wipe;
    logic rst_req;
  } irc_core_s;

  irc_core_s st;
  irc_core_s next_st;

  always_comb begin
    next_st = st;
    next_st.wr = wr_i;
    next_st.rd = rd_i;
    next_st.addr = addr_i;
    next_st.wdata = wdata_i;
    // Clear bits travel with their set bits unchanged
    // Keyed writes are forwarded unchanged; the key is software's duty
    next_st.entry_valid = entry_valid_i;
    next_st.entry_num = entry_num_i;
    next_st.active_num = active_num_i;
    next_st.halted = halted_i;
    next_st.rdata = link.rdata;
    next_st.rvalid = link.rvalid;
    next_st.irq = link.core_irq;
    next_st.nmi = link.core_nmi;
    next_st.wipe = link.wipe_active;
    next_st.rst_req = link.chip_reset_req;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Peripheral lines go raw; the controller synchronizes them
  assign link.periph_req = periph_req_i;
  assign link.wr = st.wr;
  assign link.rd = st.rd;
  assign link.addr = st.addr;
  assign link.wdata = st.wdata;
  assign link.entry_valid = st.entry_valid;
  assign link.entry_num = st.entry_num;
  assign link.active_num = st.active_num;
  assign link.halted = st.halted;
  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign core_irq_o = st.irq;
  assign core_nmi_o = st.nmi;
  assign wipe_active_o = st.wipe;
  assign chip_reset_req_o = st.rst_req;
endmodule : irc_core
`default_nettype wire

//--- verification/irc_link_sva.sv
// Checker: timing and field relations on the controller link
`timescale 1ns/1ns
`default_nettype none
module irc_link_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Link
  input wire logic wr,
  input wire logic rd,
  input wire logic [13:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic [31:0] core_irq,
  input wire logic core_nmi,
  input wire logic wipe_active,
  input wire logic chip_reset_req,
  input wire logic [5:0] active_num,
  input wire logic halted
);
  // Select field as last written; it needs no unlock
  logic [4:0] pick;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pick <= 5'h00;
    end else if (wr && addr == irc_pkg::OFF_NMI_SELECT) begin
      pick <= wdata[irc_pkg::NMI_PICK_W-1:0];
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence pend_read;
    rd && addr == irc_pkg::OFF_PEND_STATE;
  endsequence
  sequence wipe_write;
    wr && halted && addr == irc_pkg::OFF_KEYED_RESET && wdata[31:16] == irc_pkg::WRITE_KEY
      && wdata[1];
  endsequence
  read_answer_a: assert property (rvalid == $past(rd)) else $error("read answer late");
  idle_data_a: assert property (!rvalid |-> rdata == 32'h0) else $error("stray read data");
  irct_field_a: assert property (rd && addr == irc_pkg::OFF_IRCT_SRC |=> rdata[31:1] == 31'h0)
    else $error("irct identity upper bits set");
  rtc_field_a: assert property (rd && addr == irc_pkg::OFF_RTC_SRC |=> rdata[31:1] == 31'h0)
    else $error("rtc identity upper bits set");
  id_reserved_a: assert property (rd && addr == irc_pkg::OFF_CORE_ID |=> rdata[23:20] == 4'h0)
    else $error("identity reserved bits set");
  nmi_route_a: assert property (core_nmi |-> core_irq[$past(pick)])
    else $error("nmi without request");
  active_num_a: assert property (pend_read |=> rdata[5:0] == $past(active_num))
    else $error("running number wrong");
  top_nmi_a: assert property (pend_read ##1 rdata[31] |-> rdata[17:12] == irc_pkg::EXC_NMI)
    else $error("top number not nmi");
  any_wait_a: assert property (pend_read ##1 rdata[17:12] >= irc_pkg::EXC_IRQ_BASE |-> rdata[22])
    else $error("waiting flag low");
  after_halt_a: assert property (pend_read |=> rdata[23] == ($past(halted) && rdata[17:12] != 6'h0))
    else $error("after halt flag wrong");
  wipe_pulse_a: assert property (wipe_write |=> wipe_active ##1 !wipe_active)
    else $error("wipe pulse wrong");
  wipe_halt_a: assert property (wipe_active |-> $past(halted))
    else $error("wipe while running");
  reset_hold_a: assert property (chip_reset_req |=> chip_reset_req)
    else $error("reset request dropped");
endmodule // irc_link_sva
`default_nettype wire

//--- verification/testbench.sv
// Testbench: both link ends driven and observed from the software and pin side
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ****
  // Signals
  // ****
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] PM = 32'h9ec3_f03f;
  localparam logic [13:0] PEND = irc_pkg::OFF_PEND_STATE;
  localparam logic [13:0] SEL = irc_pkg::OFF_NMI_SELECT;
  localparam logic [13:0] VEC = irc_pkg::OFF_REQ_VECTOR;
  localparam logic [13:0] KEY = irc_pkg::OFF_KEYED_RESET;
  logic clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, entry_valid_i = 1'b0, halted_i = 1'b0;
  logic [13:0] addr_i = 14'h0;
  logic [31:0] wdata_i = 32'h0, periph_req_i = 32'h0, p, rdata_o, core_irq_o;
  logic [5:0] entry_num_i = 6'h0, active_num_i = 6'h0;
  logic rvalid_o, core_nmi_o, wipe_active_o, chip_reset_req_o;
  logic [63:0] note;
  logic [63:0] note_q[$];
  int fails = 0, compares = 0, wipes = 0, seed = 32'h6a71fac1;
  always #50 clk_i = ~clk_i;
  irc_link_if lnk ();
  // Identity codes arbitrary
  irc_ctrl #(.IMPL_CODE(8'h3c), .ARCH_CODE(4'h6), .PART_CODE(12'h9a5), .REV_CODE(4'h2))
    irc_ctrl_inst (.clk_i(clk_i), .srst_i(srst_i), .link(lnk));
  irc_core irc_core_inst (.clk_i(clk_i), .srst_i(srst_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .periph_req_i(periph_req_i), .entry_valid_i(entry_valid_i), .entry_num_i(entry_num_i),
    .active_num_i(active_num_i), .halted_i(halted_i), .core_irq_o(core_irq_o),
    .core_nmi_o(core_nmi_o), .wipe_active_o(wipe_active_o),
    .chip_reset_req_o(chip_reset_req_o), .link(lnk));
  irc_link_sva irc_link_sva_inst (.clk_i(clk_i), .srst_i(srst_i), .wr(lnk.wr), .rd(lnk.rd),
    .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .rvalid(lnk.rvalid),
    .core_irq(lnk.core_irq), .core_nmi(lnk.core_nmi), .wipe_active(lnk.wipe_active),
    .chip_reset_req(lnk.chip_reset_req), .active_num(lnk.active_num), .halted(lnk.halted));
  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [13:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Blocks until answered so notes never pile up past a lost answer
  task automatic rd_reg(input logic [13:0] a, input logic [31:0] e, input logic [31:0] m);
    int n;
    note_q.push_back({m, e & m});
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    for (n = 0; n < 8 && note_q.size() > 0; n++) begin
      @(posedge clk_i);
    end
    if (note_q.size() > 0) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic enter(input logic [5:0] num);
    @(posedge clk_i);
    entry_valid_i <= 1'b1;
    entry_num_i <= num;
    @(posedge clk_i);
    entry_valid_i <= 1'b0;
  endtask
  task automatic unlock();
    wr_reg(irc_pkg::OFF_UNLOCK_PORT, {24'h0, irc_pkg::UNLOCK_B0});
    wr_reg(irc_pkg::OFF_UNLOCK_PORT, {24'h0, irc_pkg::UNLOCK_B1});
    wr_reg(irc_pkg::OFF_UNLOCK_PORT, {24'h0, irc_pkg::UNLOCK_B2});
  endtask
  task automatic pins(input logic [31:0] irq, input logic nmi, input logic rst);
    repeat (6) @(posedge clk_i);
    check("core_irq", core_irq_o, irq);
    check("core_nmi", {31'h0, core_nmi_o}, {31'h0, nmi});
    check("reset_req", {31'h0, chip_reset_req_o}, {31'h0, rst});
  endtask
  always @(posedge clk_i) begin
    if (rvalid_o === 1'b1) begin
      if (note_q.size() == 0) begin
        check("stray_answer", 32'h1, 32'h0);
      end else begin
        note = note_q.pop_front();
        check("rdata", rdata_o & note[63:32], note[31:0]);
      end
    end
    if (wipe_active_o === 1'b1) begin
      wipes <= wipes + 1;
    end
  end
  // ****
  // Sequence
  // ****
  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    rd_reg(SEL, 32'h0, ALL);
    rd_reg(PEND, 32'h0, ALL);
    rd_reg(KEY, irc_pkg::KEYED_RESET_READ, ALL);
    rd_reg(irc_pkg::OFF_CORE_ID, 32'h3c06_9a52, ALL);
    rd_reg(14'h0200, 32'h0, ALL);
    for (int i = 0; i < 4; i++) begin
      p = $random(seed);
      periph_req_i <= p;
      pins(p, 1'b0, 1'b0);
      rd_reg(VEC, p, ALL);
      rd_reg(irc_pkg::OFF_IRCT_SRC, {31'h0, p[30]}, ALL);
      rd_reg(irc_pkg::OFF_RTC_SRC, {31'h0, p[31]}, ALL);
    end
    periph_req_i <= 32'h0000_0008;
    pins(32'h0000_0008, 1'b0, 1'b0);
    wr_reg(VEC, 32'h0000_0028);
    pins(32'h0000_0020, 1'b0, 1'b0);
    wr_reg(VEC, 32'h0);
    pins(32'h0000_0020, 1'b0, 1'b0);
    wr_reg(VEC, 32'h0000_0020);
    pins(32'h0, 1'b0, 1'b0);
    periph_req_i <= 32'h0000_0080;
    wr_reg(SEL, 32'h0000_0107);
    rd_reg(SEL, 32'h0000_0007, ALL);
    pins(32'h0000_0080, 1'b0, 1'b0);
    unlock();
    wr_reg(SEL, 32'h0000_0107);
    pins(32'h0000_0080, 1'b1, 1'b0);
    rd_reg(PEND, 32'h8040_2000, PM);
    enter(irc_pkg::EXC_NMI);
    rd_reg(PEND, 32'h0041_7000, PM);
    wr_reg(irc_pkg::OFF_UNLOCK_PORT, 32'h16);
    wr_reg(irc_pkg::OFF_UNLOCK_PORT, 32'h59);
    wr_reg(irc_pkg::OFF_UNLOCK_PORT, 32'h88);
    wr_reg(SEL, 32'h0);
    rd_reg(SEL, 32'h0000_0100, ALL);
    periph_req_i <= 32'h0000_0001;
    pins(32'h0000_0001, 1'b1, 1'b0);
    periph_req_i <= 32'h0;
    enter(irc_pkg::EXC_NMI);
    active_num_i <= 6'h0e;
    halted_i <= 1'b1;
    wr_reg(PEND, 32'h1400_0000);
    rd_reg(PEND, 32'h14c0_e00e, PM);
    wr_reg(PEND, 32'h0800_0000);
    rd_reg(PEND, 32'h04c0_f00e, PM);
    wr_reg(PEND, 32'h0);
    rd_reg(PEND, 32'h04c0_f00e, PM);
    wr_reg(PEND, 32'h0200_0000);
    rd_reg(PEND, 32'h0000_000e, PM);
    wr_reg(PEND, 32'h8000_0000);
    rd_reg(PEND, 32'h8080_200e, PM);
    enter(irc_pkg::EXC_NMI);
    rd_reg(PEND, 32'h0000_000e, PM);
    wr_reg(KEY, 32'h1234_0006);
    pins(32'h0, 1'b0, 1'b0);
    check("wipes", wipes, 32'h0);
    halted_i <= 1'b0;
    wr_reg(KEY, {irc_pkg::WRITE_KEY, 16'h0002});
    halted_i <= 1'b1;
    wr_reg(KEY, {irc_pkg::WRITE_KEY, 16'h0002});
    wr_reg(KEY, {irc_pkg::WRITE_KEY, 16'h0004});
    pins(32'h0, 1'b0, 1'b1);
    check("wipes", wipes, 32'h1);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    pins(32'h0, 1'b0, 1'b0);
    rd_reg(SEL, 32'h0, ALL);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
